// File: core/timer_clock_pkg.sv
/*
 * Shared constants and types for the timer clock source block:
 * APB register map, field layouts, reset values, dividers, count modes.
 * Assumes a 32-bit APB with 12-bit byte addresses.
 */
package timer_clock_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam int          ADDR_W            = 12;
    localparam logic [7:0]  CLOCK_CTRL_INDEX  = 8'h8E;
    localparam logic [11:0] ADDR_CLOCK_CTRL   = {2'b00, CLOCK_CTRL_INDEX, 2'b00};
    localparam logic [11:0] ADDR_TIMER_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_COUNT0       = 12'h004;
    localparam logic [11:0] COUNT_STRIDE      = 12'h004;
    localparam logic [11:0] ADDR_RELOAD_THIRD = 12'h014;
    localparam logic [11:0] ADDR_RELOAD_FOURTH = 12'h018;
    localparam logic [11:0] ADDR_IRQ_STATUS   = 12'h01C;
    localparam logic [11:0] ADDR_IRQ_CLEAR    = 12'h020;
    localparam logic [11:0] ADDR_IRQ_ENABLE   = 12'h024;

    // ------------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------------
    localparam int          NUM_TIMERS        = 4;
    localparam int          COUNT_W           = 16;
    localparam int          BYTE_W            = 8;
    localparam int          IRQ_W             = 2 * NUM_TIMERS;
    localparam int          TIMER_CTRL_W      = 14;
    localparam logic [7:0]  CLOCK_CTRL_RESET  = 8'h00;
    localparam logic [13:0] TIMER_CTRL_RESET  = 14'h0000;
    localparam logic [15:0] RELOAD_RESET      = 16'h0000;
    localparam logic [7:0]  IRQ_RESET         = 8'h00;
    localparam logic [7:0]  BYTE_FULL         = 8'hFF;
    localparam logic [4:0]  LOW13_FULL        = 5'h1F;

    // ------------------------------------------------------------------
    // clock dividers and prescale codes
    // ------------------------------------------------------------------
    localparam int          DIV_SYS_4         = 4;
    localparam int          DIV_SYS_12        = 12;
    localparam int          DIV_SYS_48        = 48;
    localparam int          DIV_EXT           = 8;
    localparam int          DIV_CNT_W         = 6;
    localparam int          EXT_CNT_W         = 3;
    localparam logic [1:0]  PRESCALE_DIV12    = 2'b00;
    localparam logic [1:0]  PRESCALE_DIV4     = 2'b01;
    localparam logic [1:0]  PRESCALE_DIV48    = 2'b10;
    localparam logic [1:0]  PRESCALE_EXT8     = 2'b11;

    // classic timer mode field codes
    localparam logic [1:0]  CLASSIC_13        = 2'b00;
    localparam logic [1:0]  CLASSIC_16        = 2'b01;
    localparam logic [1:0]  CLASSIC_RELOAD8   = 2'b10;
    localparam logic [1:0]  CLASSIC_SPLIT     = 2'b11;

    typedef enum logic [2:0] {
        MODE_13           = 3'h0,
        MODE_16           = 3'h1,
        MODE_RELOAD8      = 3'h2,
        MODE_SPLIT        = 3'h3,
        MODE_RELOAD16     = 3'h4,
        MODE_SPLIT_RELOAD = 3'h5,
        MODE_HALT         = 3'h6
    } count_mode_t;

    typedef struct packed {
        logic       fourth_timer_high_clock_sel;
        logic       fourth_timer_low_clock_sel;
        logic       third_timer_high_clock_sel;
        logic       third_timer_low_clock_sel;
        logic       second_timer_clock_sel;
        logic       first_timer_clock_sel;
        logic [1:0] prescale_field;
    } clock_ctrl_t;

    typedef struct packed {
        logic       fourth_timer_ext_clock_sel;
        logic       third_timer_ext_clock_sel;
        logic       fourth_split;
        logic       third_split;
        logic       fourth_run;
        logic       third_run;
        logic       second_run;
        logic       first_run;
        logic       second_counter_mode_bit;
        logic       first_counter_mode_bit;
        logic [1:0] second_mode;
        logic [1:0] first_mode;
    } timer_ctrl_t;

endpackage

// File: core/pin_edge_detect.sv
/*
 * Two-flop synchroniser and edge detector for one asynchronous pin.
 * Assumes the pin holds each level for at least two clock periods.
 */
`timescale 1ns/1ps
`default_nettype none

module pin_edge_detect (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic pin,
    output logic      fall,
    output logic      rise
);
    logic sync_first;
    logic sync_second;
    logic prev;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_first  <= 1'b0;
            sync_second <= 1'b0;
            prev        <= 1'b0;
        end else begin
            sync_first  <= pin;
            sync_second <= sync_first;
            prev        <= sync_second;
        end
    end

    assign fall = prev & ~sync_second;
    assign rise = ~prev & sync_second;
endmodule // pin_edge_detect

`default_nettype wire

// File: core/timer_unit.sv
/*
 * One 16-bit counter/timer with 13-bit, 16-bit, reload and split modes.
 * Assumes tick inputs are one-cycle enables on the system clock.
 */
`timescale 1ns/1ps
`default_nettype none

module timer_unit (
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire timer_clock_pkg::count_mode_t mode,
    input  wire logic                      run_lo,
    input  wire logic                      run_hi,
    input  wire logic                      tick_lo,
    input  wire logic                      tick_hi,
    input  wire logic                      load,
    input  wire logic [15:0]               load_value,
    input  wire logic [15:0]               reload_value,
    output logic      [15:0]               count,
    output logic                           ovf_lo,
    output logic                           ovf_hi
);
    import timer_clock_pkg::*;

    logic [7:0] lo;
    logic [7:0] hi;
    logic [7:0] next_lo;
    logic [7:0] next_hi;
    logic       next_ovf_lo;
    logic       next_ovf_hi;

    wire step_lo  = run_lo & tick_lo;
    wire step_hi  = run_hi & tick_hi;
    wire lo_full  = (lo == BYTE_FULL);
    wire hi_full  = (hi == BYTE_FULL);
    wire lo5_full = (lo[4:0] == LOW13_FULL);
    wire reload_b = (mode == MODE_SPLIT_RELOAD);

    assign count = {hi, lo};

    always_comb begin
        next_lo     = lo;
        next_hi     = hi;
        next_ovf_lo = 1'b0;
        next_ovf_hi = 1'b0;
        case (mode)
            MODE_13: begin
                if (step_lo) begin
                    next_lo = {lo[7:5], lo[4:0] + 5'h01};
                    if (lo5_full) begin
                        next_hi     = hi + 8'h01;
                        next_ovf_lo = hi_full;
                    end
                end
            end
            MODE_16, MODE_RELOAD16: begin
                if (step_lo) begin
                    {next_hi, next_lo} = count + 16'h0001;
                    next_ovf_lo        = lo_full & hi_full;
                    if (lo_full && hi_full && mode == MODE_RELOAD16) begin
                        {next_hi, next_lo} = reload_value;
                    end
                end
            end
            MODE_RELOAD8: begin
                if (step_lo) begin
                    next_lo     = lo_full ? hi : lo + 8'h01;
                    next_ovf_lo = lo_full;
                end
            end
            MODE_SPLIT, MODE_SPLIT_RELOAD: begin
                if (step_lo) begin
                    next_lo     = !lo_full ? lo + 8'h01 : (reload_b ? reload_value[7:0] : '0);
                    next_ovf_lo = lo_full;
                end
                if (step_hi) begin
                    next_hi     = !hi_full ? hi + 8'h01 : (reload_b ? reload_value[15:8] : '0);
                    next_ovf_hi = hi_full;
                end
            end
            default: begin
                next_lo = lo;
            end
        endcase
        if (load) begin
            {next_hi, next_lo} = load_value;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lo     <= '0;
            hi     <= '0;
            ovf_lo <= 1'b0;
            ovf_hi <= 1'b0;
        end else begin
            lo     <= next_lo;
            hi     <= next_hi;
            ovf_lo <= next_ovf_lo;
            ovf_hi <= next_ovf_hi;
        end
    end
endmodule // timer_unit

`default_nettype wire

// File: core/timer_clock_source_select.sv
/*
 * Clock source selection and counting front end for four 16-bit timers,
 * with an APB register slave and one level interrupt.
 * Assumes a single 200 MHz system clock and asynchronous count pins.
 */
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module timer_clock_source_select (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        first_count_input_pin,
    input  wire logic        second_count_input_pin,
    input  wire logic        ext_osc_clk,
    output logic             irq
);
    import timer_clock_pkg::*;

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    clock_ctrl_t        clock_ctrl;
    timer_ctrl_t        timer_ctrl;
    logic [15:0]        reload_third;
    logic [15:0]        reload_fourth;
    logic [IRQ_W-1:0]   irq_enable;
    logic [IRQ_W-1:0]   irq_status;
    logic [IRQ_W-1:0]   next_irq_status;
    logic [IRQ_W-1:0]   events;

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    wire setup       = psel & ~penable;
    wire write_fire  = psel & penable & pready & pwrite;
    wire sel_clock   = (paddr == ADDR_CLOCK_CTRL);
    wire sel_tctrl   = (paddr == ADDR_TIMER_CTRL);
    wire sel_rl3     = (paddr == ADDR_RELOAD_THIRD);
    wire sel_rl4     = (paddr == ADDR_RELOAD_FOURTH);
    wire sel_status  = (paddr == ADDR_IRQ_STATUS);
    wire sel_clear   = (paddr == ADDR_IRQ_CLEAR);
    wire sel_enable  = (paddr == ADDR_IRQ_ENABLE);

    logic [NUM_TIMERS-1:0] sel_count;
    logic [15:0]           unit_count [NUM_TIMERS];

    wire any_count   = |sel_count;
    wire addr_hit    = sel_clock | sel_tctrl | sel_rl3 | sel_rl4 | sel_status
                     | sel_clear | sel_enable | any_count;

    wire [15:0] count_read = sel_count[0] ? unit_count[0] :
                             sel_count[1] ? unit_count[1] :
                             sel_count[2] ? unit_count[2] : unit_count[3];

    wire [31:0] read_data =
        sel_clock  ? {24'h000000, clock_ctrl} :
        sel_tctrl  ? {18'h00000, timer_ctrl} :
        sel_rl3    ? {16'h0000, reload_third} :
        sel_rl4    ? {16'h0000, reload_fourth} :
        sel_status ? {24'h000000, irq_status} :
        sel_enable ? {24'h000000, irq_enable} :
        any_count  ? {16'h0000, count_read} : 32'h00000000;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~addr_hit;
            prdata  <= (setup & ~pwrite) ? read_data : 32'h00000000;
        end
    end

    // ------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clock_ctrl    <= clock_ctrl_t'(CLOCK_CTRL_RESET);
            timer_ctrl    <= timer_ctrl_t'(TIMER_CTRL_RESET);
            reload_third  <= RELOAD_RESET;
            reload_fourth <= RELOAD_RESET;
            irq_enable    <= IRQ_RESET;
        end else if (write_fire) begin
            if (sel_clock) begin
                clock_ctrl <= clock_ctrl_t'(pwdata[BYTE_W-1:0]);
            end
            if (sel_tctrl) begin
                timer_ctrl <= timer_ctrl_t'(pwdata[TIMER_CTRL_W-1:0]);
            end
            if (sel_rl3) begin
                reload_third <= pwdata[COUNT_W-1:0];
            end
            if (sel_rl4) begin
                reload_fourth <= pwdata[COUNT_W-1:0];
            end
            if (sel_enable) begin
                irq_enable <= pwdata[IRQ_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // interrupts: new events win over a clear in the same cycle
    // ------------------------------------------------------------------
    wire [IRQ_W-1:0] clear_bits = (write_fire & sel_clear) ? pwdata[IRQ_W-1:0] : IRQ_RESET;

    assign next_irq_status = (irq_status & ~clear_bits) | events;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_status <= IRQ_RESET;
            irq        <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            irq        <= |(next_irq_status & irq_enable);
        end
    end

    // ------------------------------------------------------------------
    // system clock dividers: index 0 is /4, 1 is /12, 2 is /48
    // ------------------------------------------------------------------
    localparam int DIVS [3] = '{DIV_SYS_4, DIV_SYS_12, DIV_SYS_48};
    logic [2:0] sys_div_tick;

    for (genvar d = 0; d < 3; d++) begin : g_div
        logic [DIV_CNT_W-1:0] div_cnt;
        wire div_end = (div_cnt == DIV_CNT_W'(DIVS[d] - 1));
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                div_cnt <= '0;
            end else begin
                div_cnt <= div_end ? '0 : div_cnt + 1'b1;
            end
        end
        assign sys_div_tick[d] = div_end;
    end

    // ------------------------------------------------------------------
    // pins: synchronised edge pulses
    // ------------------------------------------------------------------
    logic first_pin_fall;
    logic second_pin_fall;
    logic ext_rise;
    logic [EXT_CNT_W-1:0] ext_cnt;

    pin_edge_detect u_first_pin (
        .clk  (clk),
        .rst  (rst),
        .pin  (first_count_input_pin),
        .fall (first_pin_fall),
        .rise ()
    );

    pin_edge_detect u_second_pin (
        .clk  (clk),
        .rst  (rst),
        .pin  (second_count_input_pin),
        .fall (second_pin_fall),
        .rise ()
    );

    pin_edge_detect u_ext_osc (
        .clk  (clk),
        .rst  (rst),
        .pin  (ext_osc_clk),
        .fall (),
        .rise (ext_rise)
    );

    // external clock divided by eight, on the system clock
    wire ext_tick = ext_rise & (ext_cnt == EXT_CNT_W'(DIV_EXT - 1));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_cnt <= '0;
        end else if (ext_rise) begin
            ext_cnt <= ext_cnt + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // clock source selection
    // ------------------------------------------------------------------
    wire prescaled_tick =
        (clock_ctrl.prescale_field == PRESCALE_DIV12) ? sys_div_tick[1] :
        (clock_ctrl.prescale_field == PRESCALE_DIV4)  ? sys_div_tick[0] :
        (clock_ctrl.prescale_field == PRESCALE_DIV48) ? sys_div_tick[2] : ext_tick;

    // classic timers: system clock or prescaled clock
    wire first_timer_tick  = clock_ctrl.first_timer_clock_sel  ? 1'b1 : prescaled_tick;
    wire second_timer_tick = clock_ctrl.second_timer_clock_sel ? 1'b1 : prescaled_tick;

    // counter mode overrides the clock select
    wire first_tick  = timer_ctrl.first_counter_mode_bit  ? first_pin_fall  : first_timer_tick;
    wire second_tick = timer_ctrl.second_counter_mode_bit ? second_pin_fall : second_timer_tick;

    // reload timers: external select chooses system/12 or external/8
    wire third_base  = timer_ctrl.third_timer_ext_clock_sel  ? ext_tick : sys_div_tick[1];
    wire fourth_base = timer_ctrl.fourth_timer_ext_clock_sel ? ext_tick : sys_div_tick[1];

    wire third_lo_tick  = clock_ctrl.third_timer_low_clock_sel   ? 1'b1 : third_base;
    wire third_hi_tick  = clock_ctrl.third_timer_high_clock_sel  ? 1'b1 : third_base;
    wire fourth_lo_tick = clock_ctrl.fourth_timer_low_clock_sel  ? 1'b1 : fourth_base;
    wire fourth_hi_tick = clock_ctrl.fourth_timer_high_clock_sel ? 1'b1 : fourth_base;

    // ------------------------------------------------------------------
    // mode mapping
    // ------------------------------------------------------------------
    function automatic count_mode_t classic_mode(input logic [1:0] code, input logic split_ok);
        count_mode_t m;
        m = MODE_HALT;
        case (code)
            CLASSIC_13:      m = MODE_13;
            CLASSIC_16:      m = MODE_16;
            CLASSIC_RELOAD8: m = MODE_RELOAD8;
            CLASSIC_SPLIT:   m = split_ok ? MODE_SPLIT : MODE_HALT;
            default:         m = MODE_HALT;
        endcase
        return m;
    endfunction

    wire first_split = (timer_ctrl.first_mode == CLASSIC_SPLIT);

    count_mode_t           unit_mode   [NUM_TIMERS];
    logic [15:0]           unit_reload [NUM_TIMERS];
    logic [NUM_TIMERS-1:0] run_lo;
    logic [NUM_TIMERS-1:0] run_hi;
    logic [NUM_TIMERS-1:0] tick_lo;
    logic [NUM_TIMERS-1:0] tick_hi;
    logic [NUM_TIMERS-1:0] ovf_lo;
    logic [NUM_TIMERS-1:0] ovf_hi;

    assign unit_mode[0] = classic_mode(timer_ctrl.first_mode, 1'b1);
    assign unit_mode[1] = classic_mode(timer_ctrl.second_mode, 1'b0);
    assign unit_mode[2] = timer_ctrl.third_split  ? MODE_SPLIT_RELOAD : MODE_RELOAD16;
    assign unit_mode[3] = timer_ctrl.fourth_split ? MODE_SPLIT_RELOAD : MODE_RELOAD16;

    assign unit_reload[0] = RELOAD_RESET;
    assign unit_reload[1] = RELOAD_RESET;
    assign unit_reload[2] = reload_third;
    assign unit_reload[3] = reload_fourth;

    // in split mode the first timer's high byte runs from the second run bit
    assign run_lo  = {timer_ctrl.fourth_run, timer_ctrl.third_run,
                      timer_ctrl.second_run, timer_ctrl.first_run};
    assign run_hi  = {timer_ctrl.fourth_run, timer_ctrl.third_run,
                      timer_ctrl.second_run, first_split & timer_ctrl.second_run};
    assign tick_lo = {fourth_lo_tick, third_lo_tick, second_tick, first_tick};
    assign tick_hi = {fourth_hi_tick, third_hi_tick, second_timer_tick, first_timer_tick};

    // ------------------------------------------------------------------
    // timers
    // ------------------------------------------------------------------
    for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_timer
        assign sel_count[t] = (paddr == ADDR_COUNT0 + ADDR_W'(t) * COUNT_STRIDE);

        timer_unit u_timer (
            .clk          (clk),
            .rst          (rst),
            .mode         (unit_mode[t]),
            .run_lo       (run_lo[t]),
            .run_hi       (run_hi[t]),
            .tick_lo      (tick_lo[t]),
            .tick_hi      (tick_hi[t]),
            .load         (write_fire & sel_count[t]),
            .load_value   (pwdata[COUNT_W-1:0]),
            .reload_value (unit_reload[t]),
            .count        (unit_count[t]),
            .ovf_lo       (ovf_lo[t]),
            .ovf_hi       (ovf_hi[t])
        );

        assign events[2*t]   = ovf_lo[t];
        assign events[2*t+1] = ovf_hi[t];
    end

endmodule // timer_clock_source_select

`default_nettype wire

// File: verif/timer_clock_source_select_assertions.sv
/* checker for the timer clock block: APB timing and clock control register.
   assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module timer_clock_checker
    import timer_clock_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq
);
    // ------------------------------------------------------------
    // shadow of the clock control register
    // ------------------------------------------------------------
    logic [7:0] shadow;
    wire logic  is_cc = (paddr == ADDR_CLOCK_CTRL);
    wire logic  wr_cc = psel && penable && pready && pwrite && is_cc;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) shadow <= CLOCK_CTRL_RESET;
        else if (wr_cc) shadow <= pwdata[7:0];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_ready_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("ready held too long");
    chk_ready_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    chk_ctrl_mapped: assert property (pready && is_cc |-> !pslverr)
        else $error("clock control refused");
    chk_ctrl_readback: assert property (pready && !pwrite && is_cc |-> prdata == {24'h0, shadow})
        else $error("clock control read differs");
    chk_data_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    chk_err_data: assert property (pslverr |-> prdata == 32'h0)
        else $error("data with error");
    cover property (wr_cc);
    cover property (pslverr);
    cover property ($rose(irq));
endmodule // timer_clock_checker
bind timer_clock_source_select timer_clock_checker timer_clock_checker_i (.clk(clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
`default_nettype wire

// File: verif/timer_clock_source_select_tb_top.sv
/* self-checking bench for the timer clock block.
   assumes the checker is bound; the bench drives APB and the pins itself. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module timer_clock_source_select_tb_top;
    import timer_clock_pkg::*;
    // ------------------------------------------------------------
    // stimulus and scenarios
    // ------------------------------------------------------------
    logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pin0 = 1, pin1 = 1, err;
    logic [1:0]  ediv = 2'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd;
    logic [15:0] a;
    wire logic [31:0] prdata;
    wire logic   pready, pslverr, irq;
    wire logic   ext = ediv[1];
    int          errors = 0, checks = 0;
    timer_clock_source_select timer_clock_source_select_i (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .first_count_input_pin(pin0),
        .second_count_input_pin(pin1), .ext_osc_clk(ext), .irq(irq));
    initial forever #2.5 clk = ~clk;
    // external oscillator at a quarter of the system clock
    always @(posedge clk) ediv <= ediv + 2'h1;
    task automatic summarize;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic xfer(input logic w, input logic [11:0] ad, input logic [31:0] wd);
        int n;
        @(posedge clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= ad; pwdata <= wd;
        @(posedge clk);
        penable <= 1;
        n = 0;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin errors++; summarize(); end
        rd = prdata; err = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task automatic t_regs;
        xfer(0, ADDR_CLOCK_CTRL, 0);
        `CHK("clock ctrl reset", 32'h0, rd)
        for (int i = 0; i < 9; i++) begin
            xfer(1, ADDR_CLOCK_CTRL, (i == 8) ? 32'hFFFFFFFF : 32'h1 << i);
            xfer(0, ADDR_CLOCK_CTRL, 0);
            `CHK("clock ctrl bits", (i == 8) ? 32'hFF : 32'h1 << i, rd)
        end
        xfer(0, 12'hFFC, 0);
        `CHK("unmapped error", 1'b1, err)
        `CHK("unmapped data", 32'h0, rd)
        $display("test registers done");
    endtask
    task automatic t_rates;
        logic [7:0]  sel [5] = '{8'h04, 8'h01, 8'h00, 8'h02, 8'h03};
        logic [15:0] ex [5] = '{16'h0060, 16'h0018, 16'h0008, 16'h0002, 16'h0003};
        xfer(1, ADDR_TIMER_CTRL, 32'h41);
        for (int i = 0; i < 5; i++) begin
            xfer(1, ADDR_CLOCK_CTRL, {24'h0, sel[i]});
            xfer(0, ADDR_COUNT0, 0);
            a = rd[15:0];
            repeat (93) @(posedge clk);
            xfer(0, ADDR_COUNT0, 0);
            `CHK("ticks in 96 cycles", ex[i], rd[15:0] - a)
        end
        $display("test rates done");
    endtask
    task automatic t_irq;
        xfer(1, ADDR_IRQ_ENABLE, 0);
        xfer(1, ADDR_CLOCK_CTRL, 32'h04);
        xfer(1, ADDR_COUNT0, 32'hFFF0);
        repeat (40) @(posedge clk);
        xfer(0, ADDR_IRQ_STATUS, 0);
        `CHK("overflow status", 1'b1, rd[0])
        `CHK("masked irq", 1'b0, irq)
        xfer(1, ADDR_IRQ_ENABLE, 1);
        repeat (3) @(posedge clk);
        `CHK("irq raised", 1'b1, irq)
        xfer(1, ADDR_IRQ_CLEAR, 1);
        repeat (3) @(posedge clk);
        `CHK("irq cleared", 1'b0, irq)
        $display("test interrupt done");
    endtask
    task automatic t_counter;
        // both classic timers count pins; the second pin falls three times
        xfer(1, ADDR_TIMER_CTRL, 32'hF5);
        xfer(1, ADDR_COUNT0, 0);
        // falling edges at a quarter of the clock, two cycles per level
        for (int i = 0; i < 5; i++) begin
            pin0 <= 0;
            pin1 <= (i >= 3);
            repeat (2) @(posedge clk);
            pin0 <= 1;
            pin1 <= 1;
            repeat (2) @(posedge clk);
        end
        repeat (8) @(posedge clk);
        xfer(0, ADDR_COUNT0, 0);
        `CHK("event count", 16'h0005, rd[15:0])
        xfer(0, ADDR_COUNT0 + 12'h004, 0);
        `CHK("second event count", 16'h0003, rd[15:0])
        $display("test counter done");
    endtask
    task automatic t_reload;
        logic [31:0] tc [3] = '{32'h2300, 32'h2300, 32'h2F00};
        logic [7:0]  cc [3] = '{8'h00, 8'h50, 8'hA0};
        logic [15:0] e3 [3] = '{16'h0008, 16'h0060, 16'h6008};
        logic [15:0] e4 [3] = '{16'h0003, 16'h0060, 16'h6003};
        logic [15:0] b;
        // third on system/12, fourth on external/8; then system clock; then split
        for (int i = 0; i < 3; i++) begin
            xfer(1, ADDR_TIMER_CTRL, tc[i]);
            xfer(1, ADDR_CLOCK_CTRL, {24'h0, cc[i]});
            xfer(0, ADDR_COUNT0 + 12'h008, 0);
            a = rd[15:0];
            xfer(0, ADDR_COUNT0 + 12'h00C, 0);
            b = rd[15:0];
            repeat (90) @(posedge clk);
            xfer(0, ADDR_COUNT0 + 12'h008, 0);
            `CHK("third timer ticks", e3[i], rd[15:0] - a)
            xfer(0, ADDR_COUNT0 + 12'h00C, 0);
            `CHK("fourth timer ticks", e4[i], rd[15:0] - b)
        end
        $display("test reload clocks done");
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst <= 0;
        t_regs();
        t_rates();
        t_irq();
        t_counter();
        t_reload();
        summarize();
    end
endmodule // timer_clock_source_select_tb_top
`default_nettype wire
